// ### core/ccst_defines.vh
`ifndef CCST_DEFINES_VH
`define CCST_DEFINES_VH

// status word location in special-function space, bit-addressable
`define CCST_PSW_ADDR      8'hd0
`define CCST_PSW_RESET     8'h00

// status word field positions
`define CCST_BIT_CARRY     3'd7
`define CCST_BIT_NIBBLE    3'd6
`define CCST_BIT_USER_A    3'd5
`define CCST_BIT_BANK_HI   3'd4
`define CCST_BIT_BANK_LO   3'd3
`define CCST_BIT_OVERFLOW  3'd2
`define CCST_BIT_USER_B    3'd1
`define CCST_BIT_PARITY    3'd0

// register banks: four banks of eight bytes
`define CCST_BANK_COUNT    4
`define CCST_BANK_BYTES    8
`define CCST_BANK_AW       5

// arithmetic operation codes; all but CCST_OP_NONE touch the flags
`define CCST_OP_NONE       3'h0
`define CCST_OP_ADD        3'h1
`define CCST_OP_ADDC       3'h2
`define CCST_OP_SUBB       3'h3
`define CCST_OP_MUL        3'h4
`define CCST_OP_DIV        3'h5

// timing and instruction-set figures
`define CCST_CLK_MAX_MHZ   48
`define CCST_PEAK_MIPS     48
`define CCST_ISA_COUNT     109
`define CCST_MAX_CYCLES    4'h8

`endif

// ### core/ccst_bank_ram.v
`timescale 1ns/100ps
`default_nettype none

// small synchronous ram holding the working register banks
module ccst_bank_ram #(
  parameter AW = 5,
  parameter DW = 8
) (
  input  wire          core_clk_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] addr_in,
  input  wire [DW-1:0] wdata_in,
  output reg  [DW-1:0] rdata_out
);

  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // registered read gives the old word on a same-address write; contents are not reset
  always @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    rdata_out <= mem_q[addr_in];
  end

endmodule // ccst_bank_ram

`default_nettype wire

// ### core/ccst_core.v
// Behaviour
// - one-cycle instructions retire every clock
// - each instruction has fixed cycle count
// - flag effects follow standard core architecture
// - timing counted in plain clock cycles
// - default cycles equal instruction byte count
// - untaken branch finishes one cycle sooner
// - breakpoints, start, stop, single step
// - halted debugger reads/writes registers
// - debug uses no application-visible resources
// - bank select picks one of four banks
// - status word at 0xd0, bit-addressable
`timescale 1ns/100ps
`default_nettype none
`include "ccst_defines.vh"

module ccst_core #(
  parameter CW = 4
) (
  input  wire        core_clk_in,
  input  wire        reset_in,
  // special-function register access
  input  wire [7:0]  sfr_addr_in,
  input  wire        sfr_wr_in,
  input  wire        sfr_bit_wr_in,
  input  wire        sfr_bit_val_in,
  input  wire [7:0]  sfr_wdata_in,
  input  wire        sfr_rd_in,
  output reg  [7:0]  sfr_rdata_out,
  // arithmetic unit
  input  wire        alu_go_in,
  input  wire [2:0]  alu_op_in,
  input  wire [7:0]  alu_a_in,
  input  wire [7:0]  alu_b_in,
  input  wire [7:0]  acc_in,
  output reg  [7:0]  alu_result_out,
  output reg  [7:0]  alu_result_hi_out,
  // register bank access from the core
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [2:0]  reg_idx_in,
  input  wire [7:0]  reg_wdata_in,
  output wire [7:0]  reg_rdata_out,
  output reg         reg_rvalid_out,
  // instruction timing
  input  wire        instr_start_in,
  input  wire [15:0] instr_pc_in,
  input  wire [2:0]  instr_bytes_in,
  input  wire [CW-1:0] instr_cycles_in,
  input  wire        instr_branch_in,
  input  wire        branch_taken_in,
  output wire        instr_ready_out,
  output wire        instr_done_out,
  // debug control
  input  wire        dbg_halt_req_in,
  input  wire        dbg_run_req_in,
  input  wire        dbg_step_req_in,
  input  wire        bkpt_en_in,
  input  wire [15:0] bkpt_addr_in,
  input  wire        dbg_wr_in,
  input  wire        dbg_rd_in,
  input  wire [4:0]  dbg_addr_in,
  input  wire [7:0]  dbg_wdata_in,
  output wire [7:0]  dbg_rdata_out,
  output reg         dbg_rvalid_out,
  output wire        dbg_halted_out,
  output wire [1:0]  reg_bank_select_out
);

  localparam ST_RUN  = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_HALT = 2'd2;

  //////////////////////////////////////////////////////////////////////////////
  // functions
  // 8-bit add with carry-in; returns {carry7, carry3, signed overflow, sum}
  function [10:0] add8;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [8:0] full;
    reg   [4:0] low;
    begin
      full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      add8  = {full[8], low[4], (a[7] == b[7]) && (full[7] != a[7]), full[7:0]};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // status word storage
  reg       carry_flag_q;
  reg       nibble_carry_flag_q;
  reg       overflow_flag_q;
  reg       user_flag_a_q;
  reg       user_flag_b_q;
  reg [1:0] reg_bank_select_q;
  reg       parity_q;
  wire       psw_sel   = (sfr_addr_in == `CCST_PSW_ADDR);
  wire       psw_bit   = ((sfr_addr_in >> 3) == (`CCST_PSW_ADDR >> 3));
  wire [7:0] psw_rd    = {carry_flag_q, nibble_carry_flag_q, user_flag_a_q,
                          reg_bank_select_q, overflow_flag_q, user_flag_b_q, parity_q};
  wire [2:0] bit_pos   = sfr_addr_in[2:0];

  // software view of the status word after this cycle's write
  reg [7:0] sw_psw;
  always @* begin
    sw_psw = psw_rd;
    if (sfr_wr_in && psw_sel) begin
      sw_psw = sfr_wdata_in;
    end else if (sfr_bit_wr_in && psw_bit) begin
      sw_psw[bit_pos] = sfr_bit_val_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic flag datapath
  wire [10:0] add_res  = add8(alu_a_in, alu_b_in,
                              (alu_op_in == `CCST_OP_ADDC) ? carry_flag_q : 1'b0);
  wire [10:0] sub_res  = add8(alu_a_in, ~alu_b_in, ~carry_flag_q);
  wire [15:0] product  = {8'h00, alu_a_in} * {8'h00, alu_b_in};
  wire        div_zero = (alu_b_in == 8'h00);
  reg [7:0] res_lo;
  reg [7:0] res_hi;
  reg       nx_carry;
  reg       nx_nibble;
  reg       nx_ovf;
  reg       hit_carry;
  reg       hit_nibble;

  // flag results per operation; a borrow is the inverted carry of a + ~b
  always @* begin
    res_lo     = alu_result_out;
    res_hi     = alu_result_hi_out;
    nx_carry   = sw_psw[`CCST_BIT_CARRY];
    nx_nibble  = sw_psw[`CCST_BIT_NIBBLE];
    nx_ovf     = sw_psw[`CCST_BIT_OVERFLOW];
    hit_carry  = 1'b0;
    hit_nibble = 1'b0;
    if (alu_go_in) begin
      case (alu_op_in)
        `CCST_OP_ADD, `CCST_OP_ADDC: begin
          res_lo     = add_res[7:0];
          nx_carry   = add_res[10];
          nx_nibble  = add_res[9];
          nx_ovf     = add_res[8];
          hit_carry  = 1'b1;
          hit_nibble = 1'b1;
        end
        `CCST_OP_SUBB: begin
          res_lo     = sub_res[7:0];
          nx_carry   = ~sub_res[10];
          nx_nibble  = ~sub_res[9];
          nx_ovf     = sub_res[8];
          hit_carry  = 1'b1;
          hit_nibble = 1'b1;
        end
        `CCST_OP_MUL: begin
          res_lo    = product[7:0];
          res_hi    = product[15:8];
          nx_carry  = 1'b0;
          nx_ovf    = (product[15:8] != 8'h00);
          hit_carry = 1'b1;
        end
        `CCST_OP_DIV: begin
          // quotient and remainder left unchanged on a zero divisor
          if (!div_zero) begin
            res_lo = alu_a_in / alu_b_in;
            res_hi = alu_a_in % alu_b_in;
          end
          nx_carry  = 1'b0;
          nx_ovf    = div_zero;
          hit_carry = 1'b1;
        end
        default: res_lo = alu_result_out;
      endcase
    end
  end

  // status word registers; hardware flag update wins over a same-cycle write
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      carry_flag_q        <= 1'b0;
      nibble_carry_flag_q <= 1'b0;
      overflow_flag_q     <= 1'b0;
      user_flag_a_q       <= 1'b0;
      user_flag_b_q       <= 1'b0;
      reg_bank_select_q   <= 2'b00;
      parity_q            <= 1'b0;
      alu_result_out      <= 8'h00;
      alu_result_hi_out   <= 8'h00;
    end else begin
      carry_flag_q        <= hit_carry ? nx_carry : sw_psw[`CCST_BIT_CARRY];
      nibble_carry_flag_q <= hit_nibble ? nx_nibble : sw_psw[`CCST_BIT_NIBBLE];
      overflow_flag_q     <= nx_ovf;
      user_flag_a_q       <= sw_psw[`CCST_BIT_USER_A];
      user_flag_b_q       <= sw_psw[`CCST_BIT_USER_B];
      reg_bank_select_q   <= sw_psw[`CCST_BIT_BANK_HI:`CCST_BIT_BANK_LO];
      parity_q            <= ^acc_in;
      alu_result_out      <= res_lo;
      alu_result_hi_out   <= res_hi;
    end
  end

  // registered read port; unmapped addresses read zero
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sfr_rdata_out <= `CCST_PSW_RESET;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= psw_sel ? psw_rd : 8'h00;
    end
  end

  assign reg_bank_select_out = reg_bank_select_q;

  //////////////////////////////////////////////////////////////////////////////
  // execution timing and debug control
  reg [1:0]    state_q;
  reg [CW-1:0] cnt_q;
  reg          halt_pend_q;
  reg          step_q;
  reg          skip_bkpt_q;
  // a zero table entry means the pipelined default: one cycle per byte
  wire [CW-1:0] base_cyc = (instr_cycles_in != {CW{1'b0}}) ? instr_cycles_in
                           : {{(CW-3){1'b0}}, instr_bytes_in};
  wire [CW-1:0] eff_cyc  = (instr_branch_in && !branch_taken_in && base_cyc > 1)
                           ? base_cyc - 1'b1 : base_cyc;
  wire bkpt_hit  = bkpt_en_in && (instr_pc_in == bkpt_addr_in) && !skip_bkpt_q;
  wire accept    = (state_q == ST_RUN) && instr_start_in && !bkpt_hit && !halt_pend_q;
  wire one_cyc   = accept && (eff_cyc <= 1);
  wire exec_end  = (state_q == ST_EXEC) && (cnt_q == 1);
  wire stop_now  = halt_pend_q || dbg_halt_req_in || step_q;
  assign instr_ready_out = (state_q == ST_RUN) && !halt_pend_q && !bkpt_hit;
  assign instr_done_out  = one_cyc || exec_end;
  assign dbg_halted_out  = (state_q == ST_HALT);

  // halting only at instruction boundaries keeps interrupt state intact
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q     <= ST_RUN;
      cnt_q       <= {CW{1'b0}};
      halt_pend_q <= 1'b0;
      step_q      <= 1'b0;
      skip_bkpt_q <= 1'b0;
    end else begin
      if (dbg_halt_req_in && state_q != ST_HALT) begin
        halt_pend_q <= 1'b1;
      end
      case (state_q)
        ST_RUN: begin
          if (halt_pend_q || (instr_start_in && bkpt_hit)) begin
            state_q     <= ST_HALT;
            halt_pend_q <= 1'b0;
          end else if (accept) begin
            skip_bkpt_q <= 1'b0;
            if (one_cyc) begin
              if (stop_now) begin
                state_q     <= ST_HALT;
                halt_pend_q <= 1'b0;
                step_q      <= 1'b0;
              end
            end else begin
              cnt_q   <= eff_cyc - 1'b1;
              state_q <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          cnt_q <= cnt_q - 1'b1;
          if (exec_end) begin
            if (stop_now) begin
              state_q     <= ST_HALT;
              halt_pend_q <= 1'b0;
              step_q      <= 1'b0;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_HALT: begin
          if (dbg_step_req_in) begin
            state_q     <= ST_RUN;
            step_q      <= 1'b1;
            skip_bkpt_q <= 1'b1;
          end else if (dbg_run_req_in) begin
            state_q     <= ST_RUN;
            skip_bkpt_q <= 1'b1;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register banks, shared by core and debugger
  // the debugger owns the port only while halted, so it costs the program nothing
  wire       dbg_own  = (state_q == ST_HALT);
  wire       ram_wr   = dbg_own ? dbg_wr_in : reg_wr_in;
  wire [4:0] ram_addr = dbg_own ? dbg_addr_in
                        : {reg_bank_select_q, reg_idx_in};
  wire [7:0] ram_wd   = dbg_own ? dbg_wdata_in : reg_wdata_in;
  wire [7:0] ram_rd;

  ccst_bank_ram #(
    .AW (`CCST_BANK_AW),
    .DW (8)
  ) u_bank_ram (
    .core_clk_in (core_clk_in),
    .wr_en_in    (ram_wr),
    .addr_in     (ram_addr),
    .wdata_in    (ram_wd),
    .rdata_out   (ram_rd)
  );

  assign reg_rdata_out = ram_rd;
  assign dbg_rdata_out = ram_rd;

  // read-valid strobes one cycle after the read was taken
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rvalid_out <= 1'b0;
      dbg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in && !dbg_own;
      dbg_rvalid_out <= dbg_rd_in && dbg_own;
    end
  end

endmodule // ccst_core

`default_nettype wire

// ### sim/ccst_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ccst_core_sva #(parameter CW = 4) (
  input wire logic          core_clk_in, reset_in, sfr_wr_in, sfr_rd_in, alu_go_in, dbg_rd_in,
  input wire logic          instr_start_in, instr_branch_in, branch_taken_in, dbg_step_req_in,
  input wire logic          instr_ready_out, instr_done_out, dbg_rvalid_out, dbg_halted_out,
  input wire logic [7:0]    sfr_addr_in, sfr_wdata_in, sfr_rdata_out, acc_in, alu_a_in,
  input wire logic [7:0]    alu_b_in, alu_result_out, alu_result_hi_out,
  input wire logic [2:0]    alu_op_in, instr_bytes_in,
  input wire logic [CW-1:0] instr_cycles_in,
  input wire logic [1:0]    reg_bank_select_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // accepted three-byte start with the byte count as its length
  wire logic go3 = instr_start_in && instr_ready_out && instr_cycles_in == 0
                   && instr_bytes_in == 3'h3;
  ////////////////////////////////////////////////////////////////////////////////
  a_unmapped_read: assert property (sfr_rd_in && sfr_addr_in != 8'hd0 |=>
    sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_bank_write: assert property (sfr_wr_in && sfr_addr_in == 8'hd0 |=>
    reg_bank_select_out == 2'($past(sfr_wdata_in) >> 3)) else $error("bank select not written");
  // parity lags the accumulator by one cycle, so only a settled value is judged
  a_parity_track: assert property (sfr_rd_in && sfr_addr_in == 8'hd0 && $stable(acc_in)
    && !$past(reset_in) |=> sfr_rdata_out[0] == ^$past(acc_in)) else $error("parity wrong");
  a_add_sum: assert property (alu_go_in && alu_op_in == 3'h1 |=>
    alu_result_out == 8'($past(alu_a_in) + $past(alu_b_in))) else $error("sum wrong");
  a_mul_pair: assert property (alu_go_in && alu_op_in == 3'h4 |=>
    {alu_result_hi_out, alu_result_out} == $past(alu_a_in) * $past(alu_b_in))
    else $error("product wrong");
  a_three_byte: assert property (go3 && !instr_branch_in |-> !instr_done_out ##1
    !instr_ready_out && !instr_done_out ##1 instr_done_out) else $error("three byte timing");
  a_branch_skip: assert property (go3 && instr_branch_in && !branch_taken_in |->
    ##1 instr_done_out) else $error("untaken branch timing");
  a_branch_taken: assert property (go3 && instr_branch_in && branch_taken_in |->
    ##1 !instr_done_out ##1 instr_done_out) else $error("taken branch timing");
  a_debug_gate: assert property (dbg_rd_in |=>
    dbg_rvalid_out == $past(dbg_halted_out)) else $error("debug read gating");
  a_step_leaves: assert property (dbg_halted_out && dbg_step_req_in |=>
    !dbg_halted_out) else $error("step did not resume");
  c_branch: cover property (go3 && instr_branch_in);
  c_dbg_read: cover property (dbg_rd_in && dbg_halted_out);
  c_div_zero: cover property (alu_go_in && alu_op_in == 3'h5 && alu_b_in == 8'h00);
endmodule // ccst_core_sva
bind ccst_core ccst_core_sva #(.CW(CW)) u_sva (.*);
`default_nettype wire

// ### sim/ccst_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ccst_core_tb_top;
  logic        core_clk_in = 0, reset_in = 1, sfr_wr_in = 0, sfr_bit_wr_in = 0, sfr_bit_val_in = 0;
  logic        sfr_rd_in = 0, alu_go_in = 0, reg_wr_in = 0, reg_rd_in = 0, instr_start_in = 0;
  logic        instr_branch_in = 0, branch_taken_in = 0, dbg_halt_req_in = 0, dbg_run_req_in = 0;
  logic        dbg_step_req_in = 0, bkpt_en_in = 0, dbg_wr_in = 0, dbg_rd_in = 0;
  logic        rd_q = 0, al_q = 0;
  logic [7:0]  sfr_addr_in = '0, sfr_wdata_in = '0, alu_a_in = '0, alu_b_in = '0, acc_in = '0;
  logic [7:0]  reg_wdata_in = '0, dbg_wdata_in = '0, m = '0;
  logic [2:0]  alu_op_in = '0, reg_idx_in = '0, instr_bytes_in = 3'h1;
  logic [3:0]  instr_cycles_in = '0;
  logic [15:0] instr_pc_in = '0, bkpt_addr_in = '0, r = '0;
  logic [4:0]  dbg_addr_in = '0;
  logic [16:0] q[$];
  wire logic [7:0] sfr_rdata_out, alu_result_out, alu_result_hi_out, reg_rdata_out, dbg_rdata_out;
  wire logic   reg_rvalid_out, instr_ready_out, instr_done_out, dbg_rvalid_out, dbg_halted_out;
  wire logic [1:0] reg_bank_select_out;
  int          fail_count = 0, tests_run = 0, n = 0;
  ccst_core #(.CW(4)) dut (.*);
  always #2.5 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  // oldest note against what appeared; bit 16 asks for all sixteen bits
  task automatic chk(string nm, logic [15:0] got);
    logic [16:0] e;
    bit ok;
    e = '0;
    ok = q.size() > 0;
    if (ok) e = q.pop_front();
    tests_run++;
    if (!ok || (e[16] ? got !== e[15:0] : got[7:0] !== e[7:0])) begin
      fail_count++;
      $display("[FAIL] %s expected %h got %h", nm, e[15:0], got);
    end
  endtask
  task automatic complete_run;
    if (q.size() != 0) begin
      fail_count++;
      $display("[FAIL] pending results expected 0 got %0d", q.size());
    end
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // remember which strobes were taken so the next half cycle can judge
  always @(posedge core_clk_in) begin
    rd_q <= sfr_rd_in;
    al_q <= alu_go_in;
  end
  // watcher: judged on the falling edge, where registered answers have settled
  always @(negedge core_clk_in) begin
    n = (instr_start_in && instr_ready_out) ? 1 : n + 1;
    if (rd_q) chk("psw", sfr_rdata_out);
    if (al_q) chk("alu", {alu_result_hi_out, alu_result_out});
    if (reg_rvalid_out || dbg_rvalid_out)
      chk("bank", reg_rvalid_out ? reg_rdata_out : dbg_rdata_out);
    if (instr_done_out) chk("cycles", 16'(n));
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic rd(logic [7:0] a, logic [7:0] e);
    q.push_back({9'h0, e});
    @(posedge core_clk_in) {sfr_rd_in, sfr_addr_in} <= {1'b1, a};
    @(posedge core_clk_in) sfr_rd_in <= 1'b0;
  endtask
  task automatic rp;
    rd(8'hd0, {m[7:1], ^acc_in});
  endtask
  task automatic wr(logic [7:0] d);
    @(posedge core_clk_in) {sfr_wr_in, sfr_addr_in, sfr_wdata_in} <= {1'b1, 8'hd0, d};
    @(posedge core_clk_in) sfr_wr_in <= 1'b0;
    m = d;
  endtask
  task automatic bw(logic [2:0] b, logic v);
    @(posedge core_clk_in) {sfr_bit_wr_in, sfr_addr_in, sfr_bit_val_in} <= {1'b1, 5'h1a, b, v};
    @(posedge core_clk_in) sfr_bit_wr_in <= 1'b0;
    if (b != 0) m[b] = v;
  endtask
  // flag model: carry and nibble carry with the stored carry as carry-in for ADDC and SUBB only, overflow signed, product size or zero divisor
  task automatic alu(logic [2:0] op, logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    logic c;
    c = m[7] && op != 1;
    if (op < 3) s = a + b + c;
    else s = a - b - c;
    if (op < 4) begin
      m[7] = s[8];
      m[6] = op < 3 ? (a[3:0] + b[3:0] + c) > 15 : a[3:0] < {1'b0, b[3:0]} + c;
      m[2] = (op < 3 ? a[7] == b[7] : a[7] != b[7]) && s[7] != a[7];
      r[7:0] = s[7:0];
    end else begin
      m[7] = 1'b0;
      m[2] = op == 4 ? (a * b) > 255 : b == 0;
      if (op == 4) r = a * b;
      else if (b != 0) r = {a % b, a / b};
    end
    q.push_back({op == 4 || (op == 5 && b != 0), r});
    @(posedge core_clk_in) {alu_go_in, alu_op_in, alu_a_in, alu_b_in} <= {1'b1, op, a, b};
    acc_in <= 8'($urandom);
    @(posedge core_clk_in) alu_go_in <= 1'b0;
  endtask
  task automatic ins(logic [2:0] b, logic [3:0] c, logic br, logic tk);
    int k;
    k = c ? c : b;
    if (br && !tk && k > 1) k--;
    q.push_back({1'b1, 16'(k)});
    @(posedge core_clk_in) {instr_start_in, instr_bytes_in, instr_cycles_in} <= {1'b1, b, c};
    {instr_branch_in, branch_taken_in} <= {br, tk};
    repeat (20) @(negedge core_clk_in) if (instr_ready_out) break;
    @(posedge core_clk_in) instr_start_in <= 1'b0;
  endtask
  task automatic dbg(logic [2:0] v);
    @(posedge core_clk_in) {dbg_step_req_in, dbg_run_req_in, dbg_halt_req_in} <= v;
    @(posedge core_clk_in) {dbg_step_req_in, dbg_run_req_in, dbg_halt_req_in} <= 3'h0;
    repeat (20) @(negedge core_clk_in) if (dbg_halted_out != v[1]) break;
  endtask
  // one bank access, by the debugger or by the core; a read leaves a note
  task automatic ram(bit d, bit w, logic [4:0] a, logic [7:0] x);
    if (!w) q.push_back({9'h0, x});
    @(posedge core_clk_in)
    if (d) {dbg_wr_in, dbg_rd_in, dbg_addr_in, dbg_wdata_in} <= {w, !w, a, x};
    else {reg_wr_in, reg_rd_in, reg_idx_in, reg_wdata_in} <= {w, !w, a[2:0], x};
    @(posedge core_clk_in) {dbg_wr_in, dbg_rd_in, reg_wr_in, reg_rd_in} <= 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(12998));
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(8'hd0, 8'h00);
    rd(8'hd8, 8'h00);
    wr(8'hff);
    rp();
    for (int b = 0; b < 8; b++) begin
      bw(3'(b), !b[0]);
      rp();
    end
    wr(8'h22);
    alu(3'h1, 8'hff, 8'h01);
    rp();
    for (int i = 0; i < 40; i++) begin
      alu(3'($urandom_range(1, 5)), 8'($urandom), ($urandom % 4) ? 8'($urandom) : 8'h00);
      rp();
    end
    ins(3'h3, 4'h0, 0, 0);
    ins(3'h3, 4'h0, 1, 0);
    ins(3'h3, 4'h0, 1, 1);
    ins(3'h1, 4'h0, 0, 0);
    ins(3'h2, 4'h5, 0, 0);
    repeat (12) ins(3'($urandom_range(1, 4)), 4'($urandom_range(0, 8)), 1'($urandom),
                    1'($urandom));
    dbg(3'h1);
    for (int b = 0; b < 4; b++) ram(1, 1, {2'(b), 3'h2}, 8'(8'h50 + b));
    ram(0, 1, 5'h02, 8'hee);
    ram(1, 0, 5'h1a, 8'h53);
    dbg(3'h4);
    ins(3'h2, 4'h0, 0, 0);
    repeat (20) @(negedge core_clk_in) if (dbg_halted_out) break;
    dbg(3'h2);
    for (int b = 0; b < 4; b++) begin
      wr({3'h0, 2'(b), 3'h0});
      ram(0, 0, 5'h02, 8'(8'h50 + b));
    end
    // breakpoint at the current pc: skipped once after a run, then it stops the core
    {bkpt_en_in, bkpt_addr_in, instr_pc_in} <= {1'b1, 16'h0040, 16'h0040};
    ins(3'h1, 4'h0, 0, 0);
    fork
      ins(3'h1, 4'h0, 0, 0);
      begin
        repeat (20) @(negedge core_clk_in) if (dbg_halted_out) break;
        tests_run++;
        if (dbg_halted_out !== 1'b1) begin
          fail_count++;
          $display("[FAIL] breakpoint halt expected 1 got %b", dbg_halted_out);
        end
        dbg(3'h2);
      end
    join
    bkpt_en_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    complete_run();
  end
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end
endmodule // ccst_core_tb_top
`default_nettype wire
